// ### design/isx_exec.sv
// Functional notes
// - Compare-exchange 0F B0/B1, 5/7/8 clocks, six flags.
// - Opcode 99 sign-fills data register, 1/2 clocks.
// - Opcode 98 extends accumulator, 3 clocks.
// - Opcode 27 decimal adjust add, 4 clocks.
// - Opcode 2F decimal adjust subtract, 4 clocks.
// - Decrement keeps carry; 1/3/5 clocks.
// - Unsigned divide with per-width clock counts.
// - Divide checks operands before committing result.
// - Opcode C8 frame entry, 7/10/6+4L clocks.
// - Only modified flags change, others preserved.
// - Real mode beyond FFFFh raises 13.
// - Real mode stack overrun raises 12.
// - Protected limit or rights failure raises 13.
// - Protected stack limit failure raises 12.
// - Protected-only opcode in real mode raises 6.
// - Bus lock held during descriptor accesses.
// - Descriptor accesses assert bus lock via the lockDesc control bit.
// - Far transfer privilege violation raises 13.
// - Transfer target beyond code limit raises 13.
// - I/O-privileged with privilege above I/O level raises 13.
// - Halt needs privilege 0 in protected mode.
// - Task-switched clear allowed in real mode.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "isx_exec_regs.svh"

module isx_exec #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busLock,
  output logic halted
);
  import isx_exec_pkg::*;

  logic [1:0] rstPipe;
  logic rstN;
  isx_ctrl_t ctrl;
  isx_opcode_t opc;
  logic [31:0] eax, edx, opnd, offsetR, limitR;
  logic [11:0] flags;
  isx_state_t state;
  logic [11:0] count, lastCycles;
  logic done, excValid;
  logic [7:0] excVector;
  logic [31:0] pendEax, pendEdx, pendOpnd;
  logic [11:0] pendFlags;
  logic pendFault, pendHalt;
  logic access, wrEn, startReq, finish;
  logic [7:0] regAddr;

  // Combinational execution results
  isx_cls_t cls;
  isx_sz_t sz;
  logic memOp;
  logic [11:0] cycles;
  logic fault;
  logic [7:0] vector;
  logic [31:0] resEax, resEdx, resOpnd, szMask;
  logic [11:0] calcFlags, modMask;
  logic [63:0] dvd, quot, rem;
  logic [31:0] dvs;
  logic divOvf;
  logic [32:0] opEnd;
  logic [31:0] segLimit;
  logic [31:0] a, d, diff, decrVal;
  logic [7:0] accLow, accLowAdj;
  logic adjAux, adjCarry;

  function automatic isx_cls_t isxDecode(input isx_opcode_t o, input logic prot);
    isxDecode = ISX_CLS_BAD;
    if (o.first == `ISX_OP_TWOBYTE)
    begin
      if (o.second[7:1] == `ISX_OP_CMPX_HI)
        isxDecode = ISX_CLS_CMPX;
      else if (o.second == `ISX_OP_TSCLR)
        isxDecode = ISX_CLS_TSCLR;
      else if (o.second == `ISX_OP_SYSGRP)
        isxDecode = prot ? ISX_CLS_TSCLR : ISX_CLS_PROTONLY;
    end
    else if (o.first == `ISX_OP_SIGNX)
      isxDecode = ISX_CLS_SIGNX;
    else if (o.first == `ISX_OP_EXTW)
      isxDecode = ISX_CLS_EXTW;
    else if (o.first == `ISX_OP_ADJADD)
      isxDecode = ISX_CLS_ADJADD;
    else if (o.first == `ISX_OP_ADJSUB)
      isxDecode = ISX_CLS_ADJSUB;
    else if (o.first[7:3] == `ISX_OP_DECR_SHORT)
      isxDecode = ISX_CLS_DECRS;
    else if (o.first[7:1] == `ISX_OP_GRP_FE && o.modrm[5:3] == `ISX_MODRM_DECR)
      isxDecode = ISX_CLS_DECR;
    else if (o.first[7:1] == `ISX_OP_GRP_F6 && o.modrm[5:3] == `ISX_MODRM_DIV)
      isxDecode = ISX_CLS_DIV;
    else if (o.first == `ISX_OP_ENTER)
      isxDecode = ISX_CLS_ENTER;
    else if (o.first == `ISX_OP_HALT)
      isxDecode = ISX_CLS_HALT;
  endfunction

  function automatic logic [31:0] widthMask(input isx_sz_t s);
    case (s)
      ISX_SZ_BYTE: widthMask = 32'h000000ff;
      ISX_SZ_WORD: widthMask = 32'h0000ffff;
      default: widthMask = 32'hffffffff;
    endcase
  endfunction

  function automatic logic topBit(input logic [31:0] v, input isx_sz_t s);
    case (s)
      ISX_SZ_BYTE: topBit = v[7];
      ISX_SZ_WORD: topBit = v[15];
      default: topBit = v[31];
    endcase
  endfunction

  // Sign, zero and parity into their flag positions
  function automatic logic [11:0] szpFlags(input logic [31:0] v, input isx_sz_t s);
    szpFlags = 12'h000;
    szpFlags[`ISX_FLAG_SIGN] = topBit(v, s);
    szpFlags[`ISX_FLAG_ZERO] = ((v & widthMask(s)) == 32'h00000000);
    szpFlags[`ISX_FLAG_PARITY] = ~^v[7:0];
  endfunction

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstN = rstPipe[1];

  assign access = psel & penable;
  assign wrEn = access & pready & pwrite;
  assign regAddr = 8'(paddr);
  assign startReq = wrEn && regAddr == `ISX_OFS_CTRL && pwdata[0] && state == ISX_IDLE;
  assign finish = state == ISX_EXEC && count == 12'h000;

  always_comb
  begin
    cls = isxDecode(opc, ctrl.protMode);
    memOp = opc.modrm[7:6] != 2'h3;
    sz = ctrl.opSize32 ? ISX_SZ_DWORD : ISX_SZ_WORD;
    if (cls == ISX_CLS_CMPX && !opc.second[0])
      sz = ISX_SZ_BYTE;
    if ((cls == ISX_CLS_DECR || cls == ISX_CLS_DIV) && !opc.first[0])
      sz = ISX_SZ_BYTE;
    szMask = widthMask(sz);
    cycles = `ISX_CLK_FAULT;
    modMask = 12'h000;
    calcFlags = 12'h000;
    resEax = eax;
    resEdx = edx;
    resOpnd = opnd;
    fault = 1'b0;
    vector = `ISX_EXC_GP;
    a = eax & szMask;
    d = opnd & szMask;
    diff = (a - d) & szMask;
    decrVal = (d - 32'h00000001) & szMask;
    accLow = eax[7:0];
    accLowAdj = accLow;
    adjAux = 1'b0;
    adjCarry = 1'b0;
    // Shared 64/32 divider; zero divisor steered away from the array
    dvd = {edx, eax};
    dvs = opnd;
    if (sz == ISX_SZ_BYTE)
    begin
      dvd = {48'h0, eax[15:0]};
      dvs = {24'h0, opnd[7:0]};
    end
    else if (sz == ISX_SZ_WORD)
    begin
      dvd = {32'h0, edx[15:0], eax[15:0]};
      dvs = {16'h0, opnd[15:0]};
    end
    quot = dvd / {32'h0, (dvs == 32'h0) ? 32'h1 : dvs};
    rem = dvd % {32'h0, (dvs == 32'h0) ? 32'h1 : dvs};
    divOvf = (dvs == 32'h0) || (quot[63:32] != 32'h0)
      || ((quot[31:0] & ~szMask) != 32'h0);
    case (cls)
      ISX_CLS_CMPX:
      begin
        cycles = !memOp ? `ISX_CLK_CMPX_REG
          : (ctrl.cacheMiss ? `ISX_CLK_CMPX_MISS : `ISX_CLK_CMPX_HIT);
        modMask = 12'h8d5;
        calcFlags = szpFlags(diff, sz);
        calcFlags[`ISX_FLAG_CARRY] = a < d;
        calcFlags[`ISX_FLAG_AUXC] = a[4] ^ d[4] ^ diff[4];
        calcFlags[`ISX_FLAG_OVER] = (topBit(a, sz) != topBit(d, sz))
          && (topBit(diff, sz) != topBit(a, sz));
        if (a == d)
          resOpnd = (opnd & ~szMask) | (edx & szMask);
        else
          resEax = (eax & ~szMask) | d;
      end
      ISX_CLS_SIGNX:
      begin
        cycles = ctrl.protMode ? `ISX_CLK_SIGNX_PROT : `ISX_CLK_SIGNX_REAL;
        if (ctrl.opSize32)
          resEdx = {32{eax[31]}};
        else
          resEdx = {edx[31:16], {16{eax[15]}}};
      end
      ISX_CLS_EXTW:
      begin
        cycles = `ISX_CLK_EXTW;
        if (ctrl.opSize32)
          resEax = {{16{eax[15]}}, eax[15:0]};
        else
          resEax = {eax[31:16], {8{eax[7]}}, eax[7:0]};
      end
      ISX_CLS_ADJADD, ISX_CLS_ADJSUB:
      begin
        cycles = `ISX_CLK_DAX;
        modMask = 12'h0d5;
        if (accLow[3:0] > 4'h9 || flags[`ISX_FLAG_AUXC])
        begin
          accLowAdj = (cls == ISX_CLS_ADJADD) ? accLow + 8'h06 : accLow - 8'h06;
          adjAux = 1'b1;
        end
        if (accLow > 8'h99 || flags[`ISX_FLAG_CARRY])
        begin
          accLowAdj = (cls == ISX_CLS_ADJADD) ? accLowAdj + 8'h60 : accLowAdj - 8'h60;
          adjCarry = 1'b1;
        end
        resEax = {eax[31:8], accLowAdj};
        calcFlags = szpFlags({24'h0, accLowAdj}, ISX_SZ_BYTE);
        calcFlags[`ISX_FLAG_AUXC] = adjAux;
        calcFlags[`ISX_FLAG_CARRY] = adjCarry;
      end
      ISX_CLS_DECR, ISX_CLS_DECRS:
      begin
        cycles = (cls == ISX_CLS_DECRS || !memOp) ? `ISX_CLK_DECR_REG
          : (ctrl.cacheMiss ? `ISX_CLK_DECR_MISS : `ISX_CLK_DECR_HIT);
        // Carry deliberately outside the mask
        modMask = 12'h8d4;
        calcFlags = szpFlags(decrVal, sz);
        calcFlags[`ISX_FLAG_AUXC] = d[3:0] == 4'h0;
        calcFlags[`ISX_FLAG_OVER] = d == ((szMask >> 1) + 32'h1);
        resOpnd = (opnd & ~szMask) | decrVal;
      end
      ISX_CLS_DIV:
      begin
        case (sz)
          ISX_SZ_BYTE: cycles = !memOp ? `ISX_CLK_DIVB_REG
            : (ctrl.cacheMiss ? `ISX_CLK_DIVB_MISS : `ISX_CLK_DIVB_HIT);
          ISX_SZ_WORD: cycles = !memOp ? `ISX_CLK_DIVW_REG
            : (ctrl.cacheMiss ? `ISX_CLK_DIVW_MISS : `ISX_CLK_DIVW_HIT);
          default: cycles = !memOp ? `ISX_CLK_DIVD_REG
            : (ctrl.cacheMiss ? `ISX_CLK_DIVD_MISS : `ISX_CLK_DIVD_HIT);
        endcase
        if (sz == ISX_SZ_BYTE)
          resEax = {eax[31:16], rem[7:0], quot[7:0]};
        else if (sz == ISX_SZ_WORD)
        begin
          resEax = {eax[31:16], quot[15:0]};
          resEdx = {edx[31:16], rem[15:0]};
        end
        else
        begin
          resEax = quot[31:0];
          resEdx = rem[31:0];
        end
      end
      ISX_CLS_ENTER:
      begin
        if (opc.level == 8'h00)
          cycles = `ISX_CLK_ENTER_L0;
        else if (opc.level == 8'h01)
          cycles = `ISX_CLK_ENTER_L1;
        else
          cycles = `ISX_CLK_ENTER_BASE + `ISX_CLK_ENTER_PER * {4'h0, opc.level};
      end
      ISX_CLS_HALT: cycles = `ISX_CLK_HALT;
      ISX_CLS_TSCLR: cycles = `ISX_CLK_TSCLR;
      default: cycles = `ISX_CLK_FAULT;
    endcase
    // Memory end address, 33 bits so a wrap past the top still faults
    opEnd = {1'b0, offsetR} + ((sz == ISX_SZ_BYTE) ? 33'h0 : (sz == ISX_SZ_WORD) ? 33'h1 : 33'h3);
    segLimit = ctrl.protMode ? limitR : `ISX_REAL_LIMIT;
    // Fault priority, highest first
    if (cls == ISX_CLS_BAD || cls == ISX_CLS_PROTONLY)
    begin
      fault = 1'b1;
      vector = `ISX_EXC_UD;
    end
    else if (ctrl.ioPriv && ctrl.currentPrivilegeLevel > ctrl.ioPrivilegeLevel)
      fault = 1'b1;
    else if (cls == ISX_CLS_HALT && ctrl.protMode && ctrl.currentPrivilegeLevel != 2'h0)
      fault = 1'b1;
    else if (ctrl.farXfer && ctrl.privViol)
      fault = 1'b1;
    else if (ctrl.farXfer && {1'b0, offsetR} > {1'b0, limitR})
      fault = 1'b1;
    else if ((memOp && (cls == ISX_CLS_CMPX || cls == ISX_CLS_DECR || cls == ISX_CLS_DIV))
      || cls == ISX_CLS_ENTER)
    begin
      if (opEnd > {1'b0, segLimit})
      begin
        fault = 1'b1;
        vector = ctrl.stackSeg ? `ISX_EXC_SS : `ISX_EXC_GP;
      end
      else if (ctrl.protMode && !ctrl.accessOk)
        fault = 1'b1;
    end
    if (!fault && cls == ISX_CLS_DIV && divOvf)
    begin
      fault = 1'b1;
      vector = `ISX_EXC_DE;
    end
    if (fault)
      cycles = `ISX_CLK_FAULT;
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      state <= ISX_IDLE;
      count <= 12'h000;
    end
    else if (startReq)
    begin
      state <= ISX_EXEC;
      count <= cycles - 12'h001;
    end
    else if (finish)
      state <= ISX_IDLE;
    else if (state == ISX_EXEC)
      count <= count - 12'h001;
  end

  // Results latched at start so bus writes during execution cannot disturb them
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      pendEax <= 32'h0;
      pendEdx <= 32'h0;
      pendOpnd <= 32'h0;
      pendFlags <= 12'h000;
      pendFault <= 1'b0;
      pendHalt <= 1'b0;
      excVector <= 8'h00;
      lastCycles <= 12'h000;
    end
    else if (startReq)
    begin
      pendEax <= resEax;
      pendEdx <= resEdx;
      pendOpnd <= resOpnd;
      pendFlags <= (flags & ~modMask) | (calcFlags & modMask);
      pendFault <= fault;
      pendHalt <= cls == ISX_CLS_HALT && !fault;
      excVector <= fault ? vector : 8'h00;
      lastCycles <= cycles;
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      done <= 1'b0;
      excValid <= 1'b0;
      halted <= 1'b0;
    end
    else if (finish)
    begin
      done <= 1'b1;
      excValid <= pendFault;
      halted <= pendHalt;
    end
    else if (startReq)
    begin
      done <= 1'b0;
      excValid <= 1'b0;
      halted <= 1'b0;
    end
  end

  // Lock spans the whole execution of a descriptor-touching instruction
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      busLock <= 1'b0;
    else if (startReq)
      busLock <= ctrl.lockDesc;
    else if (finish)
      busLock <= 1'b0;
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl <= '0;
      opc <= '0;
      offsetR <= 32'h0;
      limitR <= 32'h0;
    end
    else if (wrEn)
    begin
      case (regAddr)
        `ISX_OFS_CTRL: ctrl <= {18'h0, pwdata[13:1], 1'b0};
        `ISX_OFS_OPCODE: opc <= pwdata;
        `ISX_OFS_OFFSET: offsetR <= pwdata;
        `ISX_OFS_LIMIT: limitR <= pwdata;
        default: ;
      endcase
    end
  end

  // Commit beats a same-cycle bus write; a faulted instruction writes nothing back
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      eax <= 32'h0;
      edx <= 32'h0;
      opnd <= 32'h0;
      flags <= `ISX_FLAGS_RESET;
    end
    else if (finish && !pendFault)
    begin
      eax <= pendEax;
      edx <= pendEdx;
      opnd <= pendOpnd;
      flags <= pendFlags;
    end
    else if (wrEn)
    begin
      case (regAddr)
        `ISX_OFS_EAX: eax <= pwdata;
        `ISX_OFS_EDX: edx <= pwdata;
        `ISX_OFS_OPND: opnd <= pwdata;
        `ISX_OFS_FLAGS: flags <= pwdata[11:0];
        default: ;
      endcase
    end
  end

  // One wait state on every access
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= access & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (access && !pready)
      begin
        case (regAddr)
          `ISX_OFS_CTRL: prdata <= ctrl;
          `ISX_OFS_OPCODE: prdata <= opc;
          `ISX_OFS_EAX: prdata <= eax;
          `ISX_OFS_EDX: prdata <= edx;
          `ISX_OFS_OPND: prdata <= opnd;
          `ISX_OFS_FLAGS: prdata <= {20'h0, flags};
          `ISX_OFS_OFFSET: prdata <= offsetR;
          `ISX_OFS_LIMIT: prdata <= limitR;
          `ISX_OFS_STATUS: prdata <= {4'h0, lastCycles, excVector, 4'h0,
            halted, excValid, done, state == ISX_EXEC};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule // isx_exec

// ### design/isx_exec_regs.svh
`ifndef ISX_EXEC_REGS_SVH
`define ISX_EXEC_REGS_SVH

// Register byte offsets
`define ISX_OFS_CTRL 8'h00
`define ISX_OFS_OPCODE 8'h04
`define ISX_OFS_EAX 8'h08
`define ISX_OFS_EDX 8'h0c
`define ISX_OFS_OPND 8'h10
`define ISX_OFS_FLAGS 8'h14
`define ISX_OFS_OFFSET 8'h18
`define ISX_OFS_LIMIT 8'h1c
`define ISX_OFS_STATUS 8'h20

// Flag bit positions in the flags register
`define ISX_FLAG_CARRY 0
`define ISX_FLAG_PARITY 2
`define ISX_FLAG_AUXC 4
`define ISX_FLAG_ZERO 6
`define ISX_FLAG_SIGN 7
`define ISX_FLAG_OVER 11
`define ISX_FLAGS_RESET 12'h002

// Opcode bytes and patterns
`define ISX_OP_TWOBYTE 8'h0f
`define ISX_OP_CMPX_HI 7'h58
`define ISX_OP_SIGNX 8'h99
`define ISX_OP_EXTW 8'h98
`define ISX_OP_ADJADD 8'h27
`define ISX_OP_ADJSUB 8'h2f
`define ISX_OP_DECR_SHORT 5'h09
`define ISX_OP_GRP_FE 7'h7f
`define ISX_OP_GRP_F6 7'h7b
`define ISX_OP_ENTER 8'hc8
`define ISX_OP_HALT 8'hf4
`define ISX_OP_TSCLR 8'h06
`define ISX_OP_SYSGRP 8'h00
`define ISX_MODRM_DECR 3'h1
`define ISX_MODRM_DIV 3'h6

// Exception vectors
`define ISX_EXC_DE 8'h00
`define ISX_EXC_UD 8'h06
`define ISX_EXC_SS 8'h0c
`define ISX_EXC_GP 8'h0d

`define ISX_REAL_LIMIT 32'h0000ffff

// Clock counts
`define ISX_CLK_CMPX_REG 12'd5
`define ISX_CLK_CMPX_HIT 12'd7
`define ISX_CLK_CMPX_MISS 12'd8
`define ISX_CLK_SIGNX_REAL 12'd1
`define ISX_CLK_SIGNX_PROT 12'd2
`define ISX_CLK_EXTW 12'd3
`define ISX_CLK_DAX 12'd4
`define ISX_CLK_DECR_REG 12'd1
`define ISX_CLK_DECR_HIT 12'd3
`define ISX_CLK_DECR_MISS 12'd5
`define ISX_CLK_DIVB_REG 12'd13
`define ISX_CLK_DIVB_HIT 12'd15
`define ISX_CLK_DIVB_MISS 12'd17
`define ISX_CLK_DIVW_REG 12'd21
`define ISX_CLK_DIVW_HIT 12'd22
`define ISX_CLK_DIVW_MISS 12'd24
`define ISX_CLK_DIVD_REG 12'd38
`define ISX_CLK_DIVD_HIT 12'd39
`define ISX_CLK_DIVD_MISS 12'd40
`define ISX_CLK_ENTER_L0 12'd7
`define ISX_CLK_ENTER_L1 12'd10
`define ISX_CLK_ENTER_BASE 12'd6
`define ISX_CLK_ENTER_PER 12'd4
`define ISX_CLK_HALT 12'd3
`define ISX_CLK_TSCLR 12'd4
`define ISX_CLK_FAULT 12'd1

`endif

// ### design/isx_exec_pkg.sv
package isx_exec_pkg;

  typedef enum logic [3:0] {
    ISX_CLS_BAD, ISX_CLS_CMPX, ISX_CLS_SIGNX, ISX_CLS_EXTW, ISX_CLS_ADJADD, ISX_CLS_ADJSUB,
    ISX_CLS_DECR, ISX_CLS_DECRS, ISX_CLS_DIV, ISX_CLS_ENTER, ISX_CLS_HALT, ISX_CLS_TSCLR,
    ISX_CLS_PROTONLY
  } isx_cls_t;

  typedef enum logic [1:0] {ISX_SZ_BYTE, ISX_SZ_WORD, ISX_SZ_DWORD} isx_sz_t;

  typedef enum {ISX_IDLE, ISX_EXEC} isx_state_t;

  typedef struct packed {
    logic [17:0] rsvd;
    logic lockDesc;
    logic privViol;
    logic farXfer;
    logic ioPriv;
    logic accessOk;
    logic stackSeg;
    logic cacheMiss;
    logic opSize32;
    logic [1:0] ioPrivilegeLevel;
    logic [1:0] currentPrivilegeLevel;
    logic protMode;
    logic start;
  } isx_ctrl_t;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] modrm;
    logic [7:0] second;
    logic [7:0] first;
  } isx_opcode_t;

endpackage

// ### dv/isx_mem_model.sv
`timescale 1ns/1ps
module isx_mem_model (
  input wire logic [7:0] addr,
  output logic [31:0] data,
  output logic miss
);
  // Top address bit marks a line missing from the cache, so one table gives both speeds
  always_comb
  begin
    data = {4{addr ^ 8'h5a}};
    miss = addr[7];
  end
endmodule // isx_mem_model

// ### dv/isx_exec_properties.sv
`timescale 1ns/1ps
module isx_exec_properties #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busLock,
  input wire logic halted
);
  logic startTaken;
  logic lockArm;
  logic [10:0] lockCnt;

  assign startTaken = psel && penable && pready && pwrite && paddr[7:0] == 8'h00 && pwdata[0];

  // Lock bit of the last control write, which decode uses at start
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      lockArm <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr[7:0] == 8'h00)
      lockArm <= pwdata[13];
  end

  // Longest lock is a deep frame entry
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      lockCnt <= 11'h000;
    else
      lockCnt <= busLock ? lockCnt + 11'h001 : 11'h000;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("pready not after one wait state");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  chk_err_unmapped: assert property (pready |->
    pslverr == (paddr[7:0] > 8'h20 || paddr[1:0] != 2'h0))
    else $error("pslverr does not match address map");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  chk_lock_cause: assert property ($rose(busLock) |-> $past(startTaken && lockArm))
    else $error("bus lock without locked start");
  chk_lock_bound: assert property (lockCnt <= 11'h406)
    else $error("bus lock held too long");
  chk_halt_clear: assert property (halted && startTaken |=> !halted)
    else $error("halted not cleared by start");
  chk_halt_unlock: assert property ($rose(halted) |-> !busLock)
    else $error("halted while bus locked");
endmodule // isx_exec_properties

bind isx_exec isx_exec_properties #(.ADDR_WIDTH(ADDR_WIDTH)) i_isx_exec_properties (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busLock(busLock), .halted(halted));

// ### dv/tb_top.sv
`timescale 1ns/1ps
`include "isx_exec_regs.svh"
module tb_top;
  localparam logic [31:0] AOK = 32'h200;
  localparam logic [31:0] D32 = 32'h40;
  localparam logic [31:0] PRT = 32'h2;
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [31:0] FM = 32'h8d5;
  localparam logic [31:0] DVC [4] = '{AOK, AOK, AOK | D32, AOK | D32 | 32'h80};
  localparam logic [31:0] DVO [4] = '{32'h00f000f6, 32'h00f000f7, 32'h003000f7, 32'h003000f7};
  localparam logic [11:0] DVN [4] = '{12'h00d, 12'h015, 12'h027, 12'h028};
  localparam logic [7:0] ENL [4] = '{8'h00, 8'h01, 8'h02, 8'hff};
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busLock;
  logic halted;
  logic [7:0] memAddr = 8'h00;
  logic [31:0] memData;
  logic memMiss;
  int errorCnt = 0;
  int compares = 0;

  always #2 clock = ~clock;

  isx_exec i_isx_exec (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busLock(busLock), .halted(halted));
  isx_mem_model i_isx_mem_model (.addr(memAddr), .data(memData), .miss(memMiss));

  task automatic endSim();
    $display("compares %0d errors %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask

  // Idle edge first, so back-to-back calls never drive psel twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      errorCnt++;
      endSim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q & m, exp);
  endtask

  // Decode sees CTRL as it stood before the start write, hence the double write
  task automatic run(input logic [31:0] ctrl, input logic [31:0] op, input logic [11:0] cyc,
                     input logic [7:0] vec, input logic exc);
    logic [31:0] st;
    logic lk;
    logic e;
    int n;
    wr(`ISX_OFS_OPCODE, op);
    wr(`ISX_OFS_CTRL, ctrl);
    wr(`ISX_OFS_CTRL, ctrl | 32'h1);
    @(posedge clock);
    lk = busLock;
    n = 0;
    do
    begin
      apb(1'b0, `ISX_OFS_STATUS, 32'h0, st, e);
      n++;
    end
    while (st[1] !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      errorCnt++;
      endSim();
    end
    st = {4'h0, st[27:16], 6'h0, lk, st[2], exc ? st[15:8] : 8'h00};
    check(st, {4'h0, cyc, 6'h0, ctrl[13], exc, vec});
  endtask

  task automatic flt(input logic [31:0] ctrl, input logic [31:0] op, input logic [31:0] ofs,
                     input logic [31:0] lim, input logic [7:0] vec);
    wr(`ISX_OFS_OFFSET, ofs);
    wr(`ISX_OFS_LIMIT, lim);
    wr(`ISX_OFS_OPND, 32'h77);
    run(ctrl, op, 12'h001, vec, 1'b1);
    rdChk(`ISX_OFS_OPND, ALL, 32'h77);
  endtask

  task automatic tReset();
    logic [31:0] q;
    logic e;
    rdChk(`ISX_OFS_FLAGS, 32'hfff, 32'h002);
    rdChk(`ISX_OFS_CTRL, ALL, 32'h0);
    apb(1'b0, 8'h40, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    wr(`ISX_OFS_STATUS, ALL);
    rdChk(`ISX_OFS_STATUS, ALL, 32'h0);
  endtask

  task automatic tConv();
    wr(`ISX_OFS_FLAGS, FM);
    wr(`ISX_OFS_EAX, 32'h80000000);
    wr(`ISX_OFS_EDX, 32'h0);
    run(AOK | D32, 32'h99, 12'h001, 8'h00, 1'b0);
    rdChk(`ISX_OFS_EDX, ALL, ALL);
    run(AOK | D32 | PRT, 32'h99, 12'h002, 8'h00, 1'b0);
    run(AOK | D32 | PRT, 32'h98, 12'h003, 8'h00, 1'b0);
    rdChk(`ISX_OFS_EAX, ALL, 32'h0);
    run(AOK | D32, 32'h98, 12'h003, 8'h00, 1'b0);
    rdChk(`ISX_OFS_FLAGS, FM, FM);
  endtask

  task automatic tArith();
    for (int i = 0; i < 2; i++)
    begin
      wr(`ISX_OFS_FLAGS, 32'h800);
      wr(`ISX_OFS_EAX, 32'h0f);
      run(AOK, i ? 32'h2f : 32'h27, 12'h004, 8'h00, 1'b0);
      rdChk(`ISX_OFS_EAX, ALL, i ? 32'h09 : 32'h15);
      rdChk(`ISX_OFS_FLAGS, FM, i ? 32'h814 : 32'h810);
    end
    wr(`ISX_OFS_FLAGS, 32'h001);
    wr(`ISX_OFS_OPND, 32'h1);
    run(AOK, 32'h49, 12'h001, 8'h00, 1'b0);
    rdChk(`ISX_OFS_OPND, ALL, 32'h0);
    rdChk(`ISX_OFS_FLAGS, FM, 32'h045);
    for (int i = 0; i < 2; i++)
    begin
      memAddr = i ? 8'h90 : 8'h10;
      #1;
      wr(`ISX_OFS_OPND, memData);
      run(AOK | D32 | (memMiss ? 32'h80 : 32'h0), 32'h000800ff, i ? 12'h005 : 12'h003,
          8'h00, 1'b0);
      rdChk(`ISX_OFS_OPND, ALL, memData - 32'h1);
    end
  endtask

  task automatic tDiv();
    for (int i = 0; i < 4; i++)
    begin
      wr(`ISX_OFS_EAX, 32'h64);
      wr(`ISX_OFS_EDX, 32'h0);
      wr(`ISX_OFS_OPND, 32'h7);
      run(DVC[i], DVO[i], DVN[i], 8'h00, 1'b0);
      rdChk(`ISX_OFS_EAX, ALL, i ? 32'h0e : 32'h20e);
    end
    rdChk(`ISX_OFS_EDX, ALL, 32'h2);
    wr(`ISX_OFS_OPND, 32'h0);
    run(AOK | D32, 32'h00f000f7, 12'h001, 8'h00, 1'b1);
    rdChk(`ISX_OFS_EAX, ALL, 32'h0e);
    wr(`ISX_OFS_EAX, 32'h800);
    wr(`ISX_OFS_OPND, 32'h2);
    run(AOK, 32'h00f000f6, 12'h001, 8'h00, 1'b1);
    rdChk(`ISX_OFS_EAX, ALL, 32'h800);
  endtask

  task automatic tCmpx();
    wr(`ISX_OFS_FLAGS, FM);
    wr(`ISX_OFS_EAX, 32'h5);
    wr(`ISX_OFS_OPND, 32'h5);
    wr(`ISX_OFS_EDX, 32'h33);
    run(AOK | D32, 32'h00c0b10f, 12'h005, 8'h00, 1'b0);
    rdChk(`ISX_OFS_OPND, ALL, 32'h33);
    rdChk(`ISX_OFS_FLAGS, FM, 32'h044);
    run(AOK | D32, 32'h0000b10f, 12'h007, 8'h00, 1'b0);
    rdChk(`ISX_OFS_EAX, ALL, 32'h33);
    rdChk(`ISX_OFS_FLAGS, 32'h044, 32'h004);
    run(AOK | D32 | 32'h80, 32'h0000b10f, 12'h008, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++)
      run(AOK, {ENL[i], 24'h0000c8}, ENL[i] == 8'h00 ? 12'h007 : ENL[i] == 8'h01 ? 12'h00a :
          12'h006 + 12'h004 * ENL[i], 8'h00, 1'b0);
  endtask

  task automatic tFault();
    flt(AOK | D32, 32'h000800ff, 32'hfffe, 32'h0, 8'h0d);
    flt(AOK | D32 | 32'h100, 32'h000800ff, 32'hfffe, 32'h0, 8'h0c);
    flt(AOK | D32 | PRT, 32'h000800ff, 32'h100, 32'h100, 8'h0d);
    flt(AOK | D32 | PRT | 32'h100, 32'h000800ff, 32'h100, 32'h100, 8'h0c);
    flt(D32 | PRT, 32'h000800ff, 32'h0, 32'h100, 8'h0d);
    flt(AOK, 32'h0000000f, 32'h0, 32'hffff, 8'h06);
    flt(AOK | PRT | 32'h418, 32'h99, 32'h0, 32'hffff, 8'h0d);
    flt(AOK | PRT | 32'hc, 32'hf4, 32'h0, 32'hffff, 8'h0d);
    flt(AOK | 32'h1800, 32'h99, 32'h0, 32'hffff, 8'h0d);
    flt(AOK | 32'h800, 32'h99, 32'h200, 32'h100, 8'h0d);
    run(AOK | PRT | 32'h414, 32'h99, 12'h002, 8'h00, 1'b0);
    run(AOK | 32'h3000, 32'h0000060f, 12'h004, 8'h00, 1'b0);
    run(AOK | PRT, 32'hf4, 12'h003, 8'h00, 1'b0);
    check({31'h0, halted}, 32'h1);
    run(AOK, 32'h98, 12'h003, 8'h00, 1'b0);
    check({31'h0, halted}, 32'h0);
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    tReset();
    tConv();
    tArith();
    tDiv();
    tCmpx();
    tFault();
    endSim();
  end
endmodule // tb_top
